// ### rtl/sfh_pkg.sv
// Constants and types of the slot fault status and history recorder
package sfh_pkg;
  localparam int SFH_WORD_W = 32;
  localparam int SFH_TS_W = 64;
  localparam int SFH_CODE_W = 16;
  localparam int SFH_INFO_W = 32;
  localparam int SFH_CNT_W = 16;
  localparam int SFH_NUM_CLASS = 5;
  localparam int SFH_CL_TYPE = 0;
  localparam int SFH_CL_DETACH = 1;
  localparam int SFH_CL_FUSE = 2;
  localparam int SFH_CL_RW = 3;
  localparam int SFH_CL_IFACE = 4;
  localparam int SFH_LOW_W = 5;
  localparam int SFH_HIST_D = 16;
  localparam int SFH_SYS_D = 2000;
  localparam int SFH_ORDER_D = 16;
  localparam int SFH_HEAVY_TYPES = 16;
  localparam logic [31:0] SFH_REG_STEP = 32'h0000_0004;
  localparam logic [31:0] SFH_OFF_MAP0 = 32'h0000_0000;
  localparam logic [31:0] SFH_OFF_LOW0 = 32'h0000_0014;
  localparam logic [31:0] SFH_OFF_HEAVY = 32'h0000_0028;
  localparam logic [31:0] SFH_OFF_LMAP = 32'h0000_002C;
  localparam logic [31:0] SFH_OFF_LSEL = 32'h0000_0030;
  localparam logic [31:0] SFH_OFF_LDATA = 32'h0000_0034;
  localparam logic [31:0] SFH_OFF_TMAP = 32'h0000_0038;
  localparam logic [31:0] SFH_OFF_TCNT = 32'h0000_003C;
  localparam logic [31:0] SFH_OFF_BAT_LO = 32'h0000_0040;
  localparam logic [31:0] SFH_OFF_BAT_HI = 32'h0000_0044;
  localparam logic [31:0] SFH_OFF_PCNT = 32'h0000_0048;
  localparam logic [31:0] SFH_OFF_HSEL = 32'h0000_004C;
  localparam logic [31:0] SFH_OFF_PC_LO = 32'h0000_0050;
  localparam logic [31:0] SFH_OFF_PC_HI = 32'h0000_0054;
  localparam logic [31:0] SFH_OFF_PC_FILL = 32'h0000_0058;
  localparam logic [31:0] SFH_OFF_ER_LO = 32'h0000_005C;
  localparam logic [31:0] SFH_OFF_ER_HI = 32'h0000_0060;
  localparam logic [31:0] SFH_OFF_ER_CODE = 32'h0000_0064;
  localparam logic [31:0] SFH_OFF_MD_LO = 32'h0000_0068;
  localparam logic [31:0] SFH_OFF_MD_HI = 32'h0000_006C;
  localparam logic [31:0] SFH_OFF_MD_INFO = 32'h0000_0070;
  localparam logic [31:0] SFH_OFF_MD_FILL = 32'h0000_0074;
  localparam logic [31:0] SFH_OFF_SYSSEL = 32'h0000_0078;
  localparam logic [31:0] SFH_OFF_SYSDAT = 32'h0000_007C;
  localparam logic [31:0] SFH_RST_WORD = 32'h0000_0000;
  localparam logic SFH_HRESP_OKAY = 1'b0;
  localparam logic [1:0] SFH_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    SFH_BS_IDLE = 2'b01,
    SFH_BS_WAIT = 2'b10
  } sfh_bus_state_t;
endpackage

// ### rtl/sfh_status_top.sv
// Slot fault status, event counters and history buffers behind AHB-Lite
// Function
// RULE1 - Report lowest slot with type mismatch
// RULE2 - Set per-slot bit on type mismatch
// RULE3 - Report lowest slot detached while running
// RULE4 - Set per-slot bit on detachment while running
// RULE5 - Report lowest slot with blown fuse
// RULE6 - Set per-slot bit on blown fuse
// RULE7 - Report lowest slot with I/O access failure
// RULE8 - Set per-slot bit on I/O failure
// RULE9 - Report lowest slot with interface failure
// RULE10 - Set per-slot bit on interface failure
// RULE11 - Store heavy fault code, sixteen types, nonzero (code also accepts a zero write, any value up to 16)
// RULE12 - List light fault bits in occurrence order
// RULE13 - Keep light faults as program-written bitmap
// RULE14 - Mark task retriggered while running or pending
// RULE15 - Count task collisions during program execution
// RULE16 - Stamp first battery drop, clear when normal
// RULE17 - Count power cutoffs while running
// RULE18 - Keep sixteen latest power cutoff stamps
// RULE19 - Keep sixteen latest errors: stamp, code
// RULE20 - Keep sixteen latest mode changes
// RULE21 - Keep two thousand latest system events
// RULE22 - Bit n is slot n; lowest set bit
// RULE23 - Full buffer overwrites its oldest entry (the light fault order list instead stops taking entries once it holds 16)
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module sfh_hist #(
  parameter int W = 16,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic push_in,
  input wire logic [W-1:0] data_in,
  input wire logic [AW-1:0] sel_in,
  output logic [W-1:0] data_out,
  output logic [AW:0] fill_out
);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW:0] fill_q;
  logic [AW+1:0] pos;

  if (D < 2) begin : g_chk
    $error("sfh_hist depth too small");
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wp_q <= '0;
      fill_q <= '0;
    end else if (push_in) begin
      // Wrap pointer so the oldest entry is overwritten [RULE23]
      wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      if (fill_q != (AW+1)'(D)) begin
        fill_q <= fill_q + 1'b1;
      end
    end
  end

  // Data storage needs no reset: reads are gated by the fill level
  always_ff @(posedge clk_in) begin
    if (push_in) begin
      mem_q[wp_q] <= data_in;
    end
  end

  // Select 0 is the newest entry
  always_comb begin
    pos = (AW+2)'(wp_q) + (AW+2)'(D - 1) - (AW+2)'(sel_in);
    if (pos >= (AW+2)'(D)) begin
      pos = pos - (AW+2)'(D);
    end
    data_out = ((AW+1)'(sel_in) < fill_q) ? mem_q[pos[AW-1:0]] : '0;
  end

  assign fill_out = fill_q;
endmodule

module sfh_status_top #(
  parameter int NUM_SLOTS = 16,
  parameter int NUM_TASKS = 16,
  parameter int LIGHT_BITS = 16,
  parameter int HIST_DEPTH = sfh_pkg::SFH_HIST_D,
  parameter int SYS_DEPTH = sfh_pkg::SFH_SYS_D
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic running_in,
  input wire logic [NUM_SLOTS-1:0] type_mismatch_set_in,
  input wire logic [NUM_SLOTS-1:0] detach_set_in,
  input wire logic [NUM_SLOTS-1:0] fuse_set_in,
  input wire logic [NUM_SLOTS-1:0] rw_fail_set_in,
  input wire logic [NUM_SLOTS-1:0] iface_fail_set_in,
  input wire logic [NUM_TASKS-1:0] task_trigger_in,
  input wire logic [NUM_TASKS-1:0] task_busy_in,
  input wire logic battery_low_in,
  input wire logic power_cut_in,
  input wire logic error_event_in,
  input wire logic [sfh_pkg::SFH_CODE_W-1:0] error_code_in,
  input wire logic mode_event_in,
  input wire logic [sfh_pkg::SFH_CODE_W-1:0] run_mode_in,
  input wire logic [sfh_pkg::SFH_CODE_W-1:0] restart_mode_in,
  input wire logic sys_event_in,
  input wire logic [sfh_pkg::SFH_CODE_W-1:0] sys_code_in,
  input wire logic [sfh_pkg::SFH_TS_W-1:0] timestamp_in
);
  import sfh_pkg::*;

  localparam int LW = $clog2(LIGHT_BITS);
  localparam int OAW = $clog2(SFH_ORDER_D);
  localparam int HAW = $clog2(HIST_DEPTH);
  localparam int YAW = $clog2(SYS_DEPTH);

  if (NUM_SLOTS < 2 || NUM_SLOTS > 32 || NUM_TASKS < 1 || NUM_TASKS > 32
      || LIGHT_BITS < 2 || LIGHT_BITS > 16 || HIST_DEPTH < 2
      || HIST_DEPTH > 65535 || SYS_DEPTH < 2 || SYS_DEPTH > 65535) begin : g_chk
    $error("sfh_status_top parameter out of range");
  end

  function automatic logic [SFH_LOW_W-1:0] lowest(input logic [31:0] m);
    logic [SFH_LOW_W-1:0] r;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      if (m[i]) begin
        r = SFH_LOW_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] off_at(input logic [31:0] base, input int c);
    return base + SFH_REG_STEP * 32'(c);
  endfunction

  function automatic logic [SFH_CNT_W-1:0] ones(input logic [31:0] v);
    logic [SFH_CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < 32; i++) begin
      n = n + SFH_CNT_W'(v[i]);
    end
    return n;
  endfunction

  // Bus slave: one wait state so a read always sees the previous write
  sfh_bus_state_t bs_q;
  logic [31:0] addr_q;
  logic wr_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic take;
  logic wr_go;
  logic [31:0] rd_word;

  assign take = hsel_in && hready_in && (htrans_in == SFH_HTRANS_NONSEQ);
  assign wr_go = (bs_q == SFH_BS_WAIT) && wr_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bs_q <= SFH_BS_IDLE;
      addr_q <= SFH_RST_WORD;
      wr_q <= 1'b0;
      rdata_q <= SFH_RST_WORD;
      ready_q <= 1'b1;
    end else begin
      case (bs_q)
        SFH_BS_IDLE: begin
          if (take) begin
            addr_q <= haddr_in;
            wr_q <= hwrite_in;
            ready_q <= 1'b0;
            bs_q <= SFH_BS_WAIT;
          end
        end
        SFH_BS_WAIT: begin
          ready_q <= 1'b1;
          rdata_q <= wr_q ? SFH_RST_WORD : rd_word;
          bs_q <= SFH_BS_IDLE;
        end
        default: begin
          ready_q <= 1'b1;
          bs_q <= SFH_BS_IDLE;
        end
      endcase
    end
  end

  assign hrdata_out = rdata_q;
  assign hreadyout_out = ready_q;
  assign hresp_out = SFH_HRESP_OKAY;

  // Slot fault bitmaps and their lowest slot numbers
  logic [NUM_SLOTS-1:0] smap_q [SFH_NUM_CLASS];
  logic [NUM_SLOTS-1:0] sset [SFH_NUM_CLASS];
  logic [SFH_LOW_W-1:0] low_q [SFH_NUM_CLASS];

  always_comb begin
    sset[SFH_CL_TYPE] = type_mismatch_set_in; // [RULE2]
    sset[SFH_CL_DETACH] = running_in ? detach_set_in : '0; // [RULE4]
    sset[SFH_CL_FUSE] = fuse_set_in; // [RULE6]
    sset[SFH_CL_RW] = rw_fail_set_in; // [RULE8]
    sset[SFH_CL_IFACE] = iface_fail_set_in; // [RULE10]
  end

  // Write-one clears; a new fault in the same cycle wins [RULE22]
  always_ff @(posedge core_clk_in) begin
    for (int c = 0; c < SFH_NUM_CLASS; c++) begin
      if (!resetn_in) begin
        smap_q[c] <= '0;
        low_q[c] <= '0;
      end else begin
        if (wr_go && addr_q == off_at(SFH_OFF_MAP0, c)) begin
          smap_q[c] <= (smap_q[c] & ~hwdata_in[NUM_SLOTS-1:0]) | sset[c];
        end else begin
          smap_q[c] <= smap_q[c] | sset[c];
        end
        // Lowest slot lags the bitmap by one cycle [RULE1] [RULE3] [RULE5] [RULE7] [RULE9]
        low_q[c] <= lowest(32'(smap_q[c]));
      end
    end
  end

  // Heavy external fault code
  logic [SFH_CODE_W-1:0] heavy_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      heavy_q <= '0;
    end else if (wr_go && addr_q == SFH_OFF_HEAVY
                 && hwdata_in <= 32'(SFH_HEAVY_TYPES)) begin
      heavy_q <= hwdata_in[SFH_CODE_W-1:0]; // [RULE11]
    end
  end

  // Light fault bitmap and occurrence order list
  logic [LIGHT_BITS-1:0] lmap_q;
  logic [LIGHT_BITS-1:0] lpend_q;
  logic [LIGHT_BITS-1:0] lnew;
  logic [LIGHT_BITS-1:0] lpick;
  logic [LW-1:0] lorder_q [SFH_ORDER_D];
  logic [OAW:0] lcnt_q;
  logic [OAW-1:0] lsel_q;
  logic lwr;
  logic lclr;
  logic lpush;

  assign lwr = wr_go && addr_q == SFH_OFF_LMAP;
  assign lclr = lwr && hwdata_in[LIGHT_BITS-1:0] == '0;
  assign lnew = lwr ? (hwdata_in[LIGHT_BITS-1:0] & ~lmap_q) : '0;
  assign lpick = lpend_q & (~lpend_q + 1'b1);
  assign lpush = lpend_q != '0 && lcnt_q != (OAW+1)'(SFH_ORDER_D);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      lmap_q <= '0;
    end else if (lwr) begin
      lmap_q <= hwdata_in[LIGHT_BITS-1:0]; // [RULE13]
    end
  end

  // New bits queue up and enter the list one per cycle, lowest first
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || lclr) begin
      lpend_q <= '0;
      lcnt_q <= '0;
    end else begin
      lpend_q <= (lpend_q & ~lpick) | lnew;
      if (lpush) begin
        lcnt_q <= lcnt_q + 1'b1; // [RULE12]
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (lpush) begin
      lorder_q[lcnt_q[OAW-1:0]] <= LW'(lowest(32'(lpend_q))); // [RULE12]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      lsel_q <= '0;
    end else if (wr_go && addr_q == SFH_OFF_LSEL) begin
      lsel_q <= hwdata_in[OAW-1:0];
    end
  end

  // Task collisions
  logic [NUM_TASKS-1:0] tmap_q;
  logic [NUM_TASKS-1:0] coll;
  logic [SFH_CNT_W-1:0] tcnt_q;
  logic [SFH_CNT_W-1:0] tadd;

  assign coll = task_trigger_in & task_busy_in;
  assign tadd = running_in ? ones(32'(coll)) : '0;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tmap_q <= '0;
    end else if (wr_go && addr_q == SFH_OFF_TMAP) begin
      tmap_q <= (tmap_q & ~hwdata_in[NUM_TASKS-1:0]) | coll; // [RULE14]
    end else begin
      tmap_q <= tmap_q | coll; // [RULE14]
    end
  end

  // Any write clears the counter; collisions of that cycle still count
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tcnt_q <= '0;
    end else if (wr_go && addr_q == SFH_OFF_TCNT) begin
      tcnt_q <= tadd; // [RULE15]
    end else begin
      tcnt_q <= tcnt_q + tadd; // [RULE15]
    end
  end

  // Battery drop timestamp
  logic bat_prev_q;
  logic [SFH_TS_W-1:0] bat_ts_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bat_prev_q <= 1'b0;
      bat_ts_q <= '0;
    end else begin
      bat_prev_q <= battery_low_in;
      if (!battery_low_in) begin
        bat_ts_q <= '0; // [RULE16]
      end else if (!bat_prev_q) begin
        bat_ts_q <= timestamp_in; // [RULE16]
      end
    end
  end

  // Power cutoff count
  logic [SFH_CNT_W-1:0] pcnt_q;
  logic pc_run;

  assign pc_run = power_cut_in && running_in;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pcnt_q <= '0;
    end else if (wr_go && addr_q == SFH_OFF_PCNT) begin
      pcnt_q <= SFH_CNT_W'(pc_run); // [RULE17]
    end else if (pc_run) begin
      pcnt_q <= pcnt_q + 1'b1; // [RULE17]
    end
  end

  // History buffers share one entry select; system history has its own
  logic [HAW-1:0] hsel_q;
  logic [YAW-1:0] ysel_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      hsel_q <= '0;
      ysel_q <= '0;
    end else begin
      if (wr_go && addr_q == SFH_OFF_HSEL) begin
        hsel_q <= hwdata_in[HAW-1:0];
      end
      if (wr_go && addr_q == SFH_OFF_SYSSEL) begin
        ysel_q <= hwdata_in[YAW-1:0];
      end
    end
  end

  localparam int ER_W = SFH_TS_W + SFH_CODE_W;
  localparam int MD_W = SFH_TS_W + SFH_INFO_W;

  logic [SFH_TS_W-1:0] pc_dat;
  logic [ER_W-1:0] er_dat;
  logic [MD_W-1:0] md_dat;
  logic [SFH_CODE_W-1:0] sy_dat;
  logic [HAW:0] pc_fill;
  logic [HAW:0] er_fill;
  logic [HAW:0] md_fill;
  logic [YAW:0] sy_fill;

  sfh_hist #(.W(SFH_TS_W), .D(HIST_DEPTH)) u_pcut ( // [RULE18]
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .push_in(power_cut_in),
    .data_in(timestamp_in),
    .sel_in(hsel_q),
    .data_out(pc_dat),
    .fill_out(pc_fill)
  );

  sfh_hist #(.W(ER_W), .D(HIST_DEPTH)) u_err ( // [RULE19]
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .push_in(error_event_in),
    .data_in({timestamp_in, error_code_in}),
    .sel_in(hsel_q),
    .data_out(er_dat),
    .fill_out(er_fill)
  );

  sfh_hist #(.W(MD_W), .D(HIST_DEPTH)) u_mode ( // [RULE20]
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .push_in(mode_event_in),
    .data_in({timestamp_in, run_mode_in, restart_mode_in}),
    .sel_in(hsel_q),
    .data_out(md_dat),
    .fill_out(md_fill)
  );

  sfh_hist #(.W(SFH_CODE_W), .D(SYS_DEPTH)) u_sys ( // [RULE21]
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .push_in(sys_event_in),
    .data_in(sys_code_in),
    .sel_in(ysel_q),
    .data_out(sy_dat),
    .fill_out(sy_fill)
  );

  // Read decode; unmapped addresses read as zero
  always_comb begin
    rd_word = SFH_RST_WORD;
    case (addr_q)
      SFH_OFF_HEAVY: rd_word = 32'(heavy_q);
      SFH_OFF_LMAP: rd_word = 32'(lmap_q);
      SFH_OFF_LSEL: rd_word = 32'(lsel_q);
      SFH_OFF_LDATA: begin
        rd_word = {SFH_CODE_W'(lcnt_q),
                   (32'(lsel_q) < 32'(lcnt_q)) ? SFH_CODE_W'(lorder_q[lsel_q])
                                               : SFH_CODE_W'(0)};
      end
      SFH_OFF_TMAP: rd_word = 32'(tmap_q);
      SFH_OFF_TCNT: rd_word = 32'(tcnt_q);
      SFH_OFF_BAT_LO: rd_word = bat_ts_q[0 +: SFH_WORD_W];
      SFH_OFF_BAT_HI: rd_word = bat_ts_q[SFH_WORD_W +: SFH_WORD_W];
      SFH_OFF_PCNT: rd_word = 32'(pcnt_q);
      SFH_OFF_HSEL: rd_word = 32'(hsel_q);
      SFH_OFF_PC_LO: rd_word = pc_dat[0 +: SFH_WORD_W];
      SFH_OFF_PC_HI: rd_word = pc_dat[SFH_WORD_W +: SFH_WORD_W];
      SFH_OFF_PC_FILL: rd_word = 32'(pc_fill);
      SFH_OFF_ER_LO: rd_word = er_dat[SFH_CODE_W +: SFH_WORD_W];
      SFH_OFF_ER_HI: rd_word = er_dat[SFH_CODE_W + SFH_WORD_W +: SFH_WORD_W];
      SFH_OFF_ER_CODE: begin
        rd_word = {SFH_CODE_W'(er_fill), er_dat[0 +: SFH_CODE_W]};
      end
      SFH_OFF_MD_LO: rd_word = md_dat[SFH_INFO_W +: SFH_WORD_W];
      SFH_OFF_MD_HI: rd_word = md_dat[SFH_INFO_W + SFH_WORD_W +: SFH_WORD_W];
      SFH_OFF_MD_INFO: rd_word = md_dat[0 +: SFH_INFO_W];
      SFH_OFF_MD_FILL: rd_word = 32'(md_fill);
      SFH_OFF_SYSSEL: rd_word = 32'(ysel_q);
      SFH_OFF_SYSDAT: rd_word = {SFH_CODE_W'(sy_fill), sy_dat};
      default: begin
        for (int c = 0; c < SFH_NUM_CLASS; c++) begin
          if (addr_q == off_at(SFH_OFF_MAP0, c)) begin
            rd_word = 32'(smap_q[c]);
          end
          if (addr_q == off_at(SFH_OFF_LOW0, c)) begin
            rd_word = 32'(low_q[c]);
          end
        end
      end
    endcase
  end
endmodule

// ### testbench/sfh_status_asserts.sv
// Checker for bus timing and register read bounds of the status recorder
`timescale 1ns/1ps
module sfh_status_asserts
  import sfh_pkg::*;
#(
  parameter int NUM_SLOTS = 16,
  parameter int HIST_DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic running_in,
  input wire logic [NUM_SLOTS-1:0] type_mismatch_set_in,
  input wire logic [NUM_SLOTS-1:0] detach_set_in
);
  logic tk;
  logic rd;
  assign tk = hsel_in && hready_in && htrans_in == SFH_HTRANS_NONSEQ && hreadyout_out;
  assign rd = tk && !hwrite_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_wait;
    tk |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_okay;
    hresp_out == SFH_HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  // Reset must win even though the default disable would hide it
  property p_rst;
    disable iff (1'b0) !resetn_in |=> hreadyout_out && hrdata_out == SFH_RST_WORD;
  endproperty
  a_rst: assert property (p_rst) else $error("bus outputs not idle in reset");
  property p_wr0;
    tk && hwrite_in |=> ##1 hrdata_out == SFH_RST_WORD;
  endproperty
  a_wr0: assert property (p_wr0) else $error("read data not zero after write");
  property p_hold;
    hreadyout_out && $past(hreadyout_out) |-> $stable(hrdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved while idle");
  property p_heavy;
    rd && haddr_in == SFH_OFF_HEAVY |=> ##1 hrdata_out <= 32'h0000_0010;
  endproperty
  a_heavy: assert property (p_heavy) else $error("heavy code out of range");
  property p_low;
    rd && haddr_in >= SFH_OFF_LOW0 && haddr_in < SFH_OFF_HEAVY |=> ##1 hrdata_out < NUM_SLOTS;
  endproperty
  a_low: assert property (p_low) else $error("lowest slot out of range");
  property p_tmap;
    rd && haddr_in == SFH_OFF_MAP0 |=> ##1
      (hrdata_out[NUM_SLOTS-1:0] & $past(type_mismatch_set_in, 2)) == $past(type_mismatch_set_in, 2);
  endproperty
  a_tmap: assert property (p_tmap) else $error("type map lost a set bit");
  property p_dmap;
    rd && running_in && haddr_in == SFH_OFF_MAP0 + SFH_REG_STEP |=> ##1
      (hrdata_out[NUM_SLOTS-1:0] & $past(detach_set_in, 2)) == $past(detach_set_in, 2);
  endproperty
  a_dmap: assert property (p_dmap) else $error("detach map lost a set bit");
  property p_fill;
    rd && haddr_in == SFH_OFF_PC_FILL |=> ##1 hrdata_out <= HIST_DEPTH;
  endproperty
  a_fill: assert property (p_fill) else $error("fill above depth");
endmodule

// ### testbench/testbench.sv
// Self-checking bench of the slot fault status and history recorder
`timescale 1ns/1ps
module testbench;
  import sfh_pkg::*;
  logic clk, rstn, hsel, hwrite, pcut, batt, run, eev, mev, sev;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [4:0][15:0] setv;
  logic [15:0] trig, busy, code;
  logic [63:0] ts;
  wire hrdy;
  wire hresp;
  int n_mismatch = 0;
  int n_checks = 0;
  sfh_status_top #(.SYS_DEPTH(8)) dut_u (
    .core_clk_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .running_in(run), .type_mismatch_set_in(setv[0]), .detach_set_in(setv[1]),
    .fuse_set_in(setv[2]), .rw_fail_set_in(setv[3]), .iface_fail_set_in(setv[4]),
    .task_trigger_in(trig), .task_busy_in(busy), .battery_low_in(batt),
    .power_cut_in(pcut), .error_event_in(eev), .error_code_in(code),
    .mode_event_in(mev), .run_mode_in(code), .restart_mode_in(~code),
    .sys_event_in(sev), .sys_code_in(code), .timestamp_in(ts));
  always #20 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Entered just after a rising edge; only the watchdog ends a wait that never answers
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= SFH_HTRANS_NONSEQ;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'(SFH_HRESP_OKAY));
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0000_0000, x);
    chk(nm, x, e);
  endtask
  task automatic t_reset;
    rchk(SFH_OFF_MAP0, 32'h0000_0000, "map0");
    rchk(SFH_OFF_PCNT, 32'h0000_0000, "pcnt");
    wr(32'h0000_0200, 32'hFFFF_FFFF);
    rchk(32'h0000_0200, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_slots;
    logic [31:0] m, l;
    for (int c = 0; c < 5; c++) begin
      m = SFH_OFF_MAP0 + SFH_REG_STEP * 32'(c);
      l = SFH_OFF_LOW0 + SFH_REG_STEP * 32'(c);
      setv[c] <= 16'h0208;
      rchk(m, 32'h0000_0208, "map");
      setv[c] <= 16'h0000;
      rchk(l, 32'h0000_0003, "low");
      wr(m, 32'h0000_0008);
      rchk(l, 32'h0000_0009, "low after clear");
      wr(m, 32'h0000_0200);
      rchk(m, 32'h0000_0000, "map cleared");
    end
    run <= 1'b0;
    setv[1] <= 16'h0010;
    @(posedge clk);
    setv[1] <= 16'h0000;
    rchk(SFH_OFF_MAP0 + SFH_REG_STEP, 32'h0000_0000, "detach idle");
    run <= 1'b1;
    $display("test slots done");
  endtask
  task automatic t_heavy;
    wr(SFH_OFF_HEAVY, 32'h0000_0005);
    rchk(SFH_OFF_HEAVY, 32'h0000_0005, "heavy");
    wr(SFH_OFF_HEAVY, 32'h0000_0011);
    rchk(SFH_OFF_HEAVY, 32'h0000_0005, "heavy kept");
    wr(SFH_OFF_HEAVY, 32'h0000_0010);
    rchk(SFH_OFF_HEAVY, 32'h0000_0010, "heavy max");
    $display("test heavy done");
  endtask
  task automatic t_light;
    logic [15:0] ord [4] = '{16'h1, 16'h5, 16'h0, 16'h0};
    wr(SFH_OFF_LMAP, 32'h0000_0022);
    wr(SFH_OFF_LMAP, 32'h0000_0023);
    rchk(SFH_OFF_LMAP, 32'h0000_0023, "light map");
    for (int k = 0; k < 4; k++) begin
      wr(SFH_OFF_LSEL, 32'(k));
      rchk(SFH_OFF_LDATA, {16'h0003, ord[k]}, "light order");
    end
    wr(SFH_OFF_LMAP, 32'h0000_0000);
    rchk(SFH_OFF_LDATA, 32'h0000_0000, "light cleared");
    $display("test light done");
  endtask
  task automatic t_task;
    trig <= 16'h0084;
    busy <= 16'h00FF;
    @(posedge clk);
    trig <= 16'h0000;
    run <= 1'b0;
    rchk(SFH_OFF_TCNT, 32'h0000_0002, "task count");
    trig <= 16'h0100;
    busy <= 16'h0100;
    @(posedge clk);
    trig <= 16'h0000;
    run <= 1'b1;
    rchk(SFH_OFF_TMAP, 32'h0000_0184, "task map");
    rchk(SFH_OFF_TCNT, 32'h0000_0002, "count idle");
    wr(SFH_OFF_TCNT, 32'h0000_0001);
    rchk(SFH_OFF_TCNT, 32'h0000_0000, "count clear");
    $display("test task done");
  endtask
  task automatic t_batt;
    ts <= 64'hA1B2_C3D4_0000_0011;
    batt <= 1'b1;
    repeat (3) @(posedge clk);
    ts <= 64'h0;
    rchk(SFH_OFF_BAT_LO, 32'h0000_0011, "bat lo");
    rchk(SFH_OFF_BAT_HI, 32'hA1B2_C3D4, "bat hi");
    batt <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(SFH_OFF_BAT_HI, 32'h0000_0000, "bat clear");
    $display("test battery done");
  endtask
  // Eighteen events overflow every 16-deep history and the shortened system one
  task automatic t_hist;
    for (int i = 1; i <= 18; i++) begin
      ts <= 64'hCAFE_0000_0000_0000 | 64'(i);
      code <= 16'(i);
      run <= (i < 18);
      {pcut, eev, mev, sev} <= 4'hF;
      @(posedge clk);
      {pcut, eev, mev, sev} <= 4'h0;
      @(posedge clk);
    end
    run <= 1'b1;
    rchk(SFH_OFF_PCNT, 32'h0000_0011, "cut count");
    rchk(SFH_OFF_PC_FILL, 32'h0000_0010, "cut fill");
    rchk(SFH_OFF_PC_LO, 32'h0000_0012, "cut newest");
    rchk(SFH_OFF_ER_HI, 32'hCAFE_0000, "err hi");
    rchk(SFH_OFF_ER_CODE, 32'h0010_0012, "err code");
    rchk(SFH_OFF_MD_INFO, 32'h0012_FFED, "mode info");
    wr(SFH_OFF_HSEL, 32'h0000_000F);
    rchk(SFH_OFF_PC_LO, 32'h0000_0003, "cut oldest");
    rchk(SFH_OFF_MD_LO, 32'h0000_0003, "mode oldest");
    rchk(SFH_OFF_ER_CODE, 32'h0010_0003, "err oldest");
    wr(SFH_OFF_SYSSEL, 32'h0000_0007);
    rchk(SFH_OFF_SYSDAT, 32'h0008_000B, "sys oldest");
    $display("test history done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {hsel, hwrite, pcut, batt, eev, mev, sev} = '0;
    run = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    {haddr, hwdata} = '0;
    {setv, trig, busy, code, ts} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_slots();
    t_heavy();
    t_light();
    t_task();
    t_batt();
    t_hist();
    complete_run();
  end
endmodule
bind sfh_status_top sfh_status_asserts #(.NUM_SLOTS(NUM_SLOTS), .HIST_DEPTH(HIST_DEPTH)) chk_u (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .running_in(running_in), .type_mismatch_set_in(type_mismatch_set_in),
  .detach_set_in(detach_set_in));
